//--- rtl/pfs_pkg.sv
// Shared constants and carrier types for the port A/B pin function select
package pfs_pkg;

    // Number of pins handled by the selector
    localparam int NUM_PINS = 11;

    // Pin positions inside the pin vectors
    localparam int PIN_PB2 = 0;
    localparam int PIN_PB3 = 1;
    localparam int PIN_PA0 = 2;
    localparam int PIN_PA1 = 3;
    localparam int PIN_PA2 = 4;
    localparam int PIN_PA3 = 5;
    localparam int PIN_PA4 = 6;
    localparam int PIN_PA5 = 7;
    localparam int PIN_PA6 = 8;
    localparam int PIN_PA7 = 9;
    localparam int PIN_P60 = 10;

    // Pad state after reset: strobes idle high and driven, PA7 clock driven, rest inputs
    localparam logic [10:0] PAD_OE_RST = 11'h3e0;
    localparam logic [10:0] PAD_OUT_RST = 11'h1e0;

    // Pins whose output bypasses the pad register (clock out)
    localparam logic [10:0] PAD_BYPASS = 11'h200;

    // Clock output select codes
    localparam logic CLK_SEL_SRC_A = 1'b0;
    localparam logic CLK_SEL_SRC_B = 1'b1;

    // Enables from the bus controller, serial and function control logic
    typedef struct packed {
        logic serial_ch4_tx_out_en;
        logic addr_hold_out_en;
        logic bus_status_setb_out_en;
        logic addr_strobe_out_en;
        logic external_expansion_enable;
        logic upper_byte_strobe_en;
        logic high_write_strobe_en;
        logic high_write_strobe_out_en;
        logic byte_sram_access;
        logic bus_release_enable;
        logic wait_input_enable;
        logic bus_ack_out_en;
        logic byte_sram_select;
        logic read_write_out_en;
        logic bus_status_seta_out_en;
        logic bus_request_out_en;
        logic chip_select_three_en;
        logic chip_select_seven_seta_en;
        logic chip_select_two_seta_en;
        logic chip_select_six_seta_en;
    } pfs_enable_s;

    // Output levels produced by the on-chip modules
    typedef struct packed {
        logic serial_ch4_transmit;
        logic addr_hold;
        logic bus_status_setb;
        logic addr_strobe;
        logic read_strobe;
        logic upper_byte_strobe;
        logic high_write_strobe;
        logic lower_byte_strobe;
        logic low_write_strobe;
        logic bus_ack;
        logic read_write;
        logic bus_status_seta;
        logic bus_request_out;
        logic chip_select_three;
        logic chip_select_seven_seta;
        logic chip_select_two_seta;
        logic chip_select_six_seta;
    } pfs_signal_s;

endpackage : pfs_pkg

//--- rtl/pfs_pad_stage.sv
// Output stage of one pin: registered level and driver enable
module pfs_pad_stage
    import pfs_pkg::*;
#(
    parameter logic INIT_OE = 1'b0,
    parameter logic INIT_OUT = 1'b0,
    parameter logic BYPASS = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Selected function
    input wire logic sel_out,
    input wire logic sel_oe,
    // Pad side
    output logic pad_out,
    output logic pad_oe
);

    logic out_q;
    logic oe_q;
    logic next_out;
    logic next_oe;

    // Next pad state is simply the selected function
    always_comb begin
        next_out = sel_out;
        next_oe = sel_oe;
    end

    // Register so the pad sees no mux glitches, except on the level of a bypass pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= INIT_OUT;
            oe_q <= INIT_OE;
        end else begin
            out_q <= next_out;
            oe_q <= next_oe;
        end
    end

    // A clock output cannot pass a flop of the same clock intact
    assign pad_out = BYPASS ? sel_out : out_q;
    assign pad_oe = oe_q;

endmodule : pfs_pad_stage

//--- rtl/pfs_pin_select.sv
// Pin function selector for P60, port A and port B bits 3 and 2
//
// Notes on behaviour
// - P60 sends serial data when enabled, else follows its direction.
// - PA7 drives the system clock when its direction is 1, else input.
// - The clock on PA7 follows the clock output select bit.
// - PA6: address hold, bus status B, address strobe, then port.
// - PA5 drives the read strobe under expansion, ignoring direction.
// - PA4 strobe: upper byte in byte SRAM or out enable, else write.
// - PA4 with both strobe enables clear follows its direction bit.
// - PA3 under expansion drives lower byte strobe in byte SRAM, else low write strobe.
// - PA2 is bus request input, then wait input, then a port pin.
// - PA1 drives acknowledge, then read/write, then follows direction.
// - PA0 drives bus status A, then request out, then follows direction.
// - PB3 drives chip select 3 or 7 set A when enabled, else port.
// - PB2 drives chip select 2 or 6 set A when enabled, else port.
module pfs_pin_select
    import pfs_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic ARST_N_I,
    // Function enables and module outputs
    input wire pfs_enable_s ENABLE_I,
    input wire pfs_signal_s SIGNAL_I,
    // Port direction bits, one per pin
    input wire logic [NUM_PINS-1:0] DIRECTION_I,
    // Port output data bits, one per pin
    input wire logic [NUM_PINS-1:0] PORT_DATA_I,
    // Clock output sources and select
    input wire logic CLK_SRC_A_I,
    input wire logic CLK_SRC_B_I,
    input wire logic CLOCK_OUT_SELECT_BIT_I,
    // Pad side
    input wire logic [NUM_PINS-1:0] PIN_IN_I,
    output logic [NUM_PINS-1:0] PIN_OUT_O,
    output logic [NUM_PINS-1:0] PIN_OE_O,
    // Input paths
    output logic [NUM_PINS-1:0] PORT_IN_O,
    output logic BUS_REQUEST_IN_O,
    output logic WAIT_IN_O
);

    logic [NUM_PINS-1:0] sel_out;
    logic [NUM_PINS-1:0] sel_oe;
    logic clock_out;
    logic [NUM_PINS-1:0] in_q;
    logic [NUM_PINS-1:0] next_in;
    logic bus_req_q;
    logic wait_q;
    logic next_bus_req;
    logic next_wait;

    // Clock source choice for the clock output pin
    always_comb begin
        if (CLOCK_OUT_SELECT_BIT_I == CLK_SEL_SRC_B) begin
            clock_out = CLK_SRC_B_I;
        end else begin
            clock_out = CLK_SRC_A_I;
        end
    end

    // Function priority per pin; ports default to port output or input
    always_comb begin
        // Port fallback: drive when direction is 1, else driver off
        sel_out = PORT_DATA_I;
        sel_oe = DIRECTION_I;

        // P60: serial transmit above the port
        if (ENABLE_I.serial_ch4_tx_out_en) begin
            sel_out[PIN_P60] = SIGNAL_I.serial_ch4_transmit;
            sel_oe[PIN_P60] = 1'b1;
        end

        // PA7: clock out or plain input, never port output
        sel_out[PIN_PA7] = clock_out;
        sel_oe[PIN_PA7] = DIRECTION_I[PIN_PA7];

        // PA6: three bus controller functions in fixed order
        if (ENABLE_I.addr_hold_out_en) begin
            sel_out[PIN_PA6] = SIGNAL_I.addr_hold;
            sel_oe[PIN_PA6] = 1'b1;
        end else if (ENABLE_I.bus_status_setb_out_en) begin
            sel_out[PIN_PA6] = SIGNAL_I.bus_status_setb;
            sel_oe[PIN_PA6] = 1'b1;
        end else if (ENABLE_I.addr_strobe_out_en) begin
            sel_out[PIN_PA6] = SIGNAL_I.addr_strobe;
            sel_oe[PIN_PA6] = 1'b1;
        end

        // PA5: read strobe overrides direction
        if (ENABLE_I.external_expansion_enable) begin
            sel_out[PIN_PA5] = SIGNAL_I.read_strobe;
            sel_oe[PIN_PA5] = 1'b1;
        end

        // PA4: byte or write strobe chosen per access
        if (ENABLE_I.upper_byte_strobe_en
                || ENABLE_I.high_write_strobe_en) begin
            sel_oe[PIN_PA4] = 1'b1;
            if (ENABLE_I.byte_sram_access
                    || ENABLE_I.high_write_strobe_out_en) begin
                sel_out[PIN_PA4] = SIGNAL_I.upper_byte_strobe;
            end else begin
                sel_out[PIN_PA4] = SIGNAL_I.high_write_strobe;
            end
        end else begin
            // Both strobe enables clear: plain port pin
            sel_out[PIN_PA4] = PORT_DATA_I[PIN_PA4];
            sel_oe[PIN_PA4] = DIRECTION_I[PIN_PA4];
        end

        // PA3: strobe while the external bus is in use
        if (ENABLE_I.external_expansion_enable) begin
            sel_oe[PIN_PA3] = 1'b1;
            if (ENABLE_I.byte_sram_access) begin
                sel_out[PIN_PA3] = SIGNAL_I.lower_byte_strobe;
            end else begin
                sel_out[PIN_PA3] = SIGNAL_I.low_write_strobe;
            end
        end

        // PA2: both bus functions are inputs, so the driver is off
        if (ENABLE_I.bus_release_enable
                || ENABLE_I.wait_input_enable) begin
            sel_out[PIN_PA2] = 1'b0;
            sel_oe[PIN_PA2] = 1'b0;
        end

        // PA1: acknowledge, then read/write strobe
        if (ENABLE_I.bus_ack_out_en) begin
            sel_out[PIN_PA1] = SIGNAL_I.bus_ack;
            sel_oe[PIN_PA1] = 1'b1;
        end else if (ENABLE_I.byte_sram_select
                || ENABLE_I.read_write_out_en) begin
            sel_out[PIN_PA1] = SIGNAL_I.read_write;
            sel_oe[PIN_PA1] = 1'b1;
        end

        // PA0: bus status A, then bus request out
        if (ENABLE_I.bus_status_seta_out_en) begin
            sel_out[PIN_PA0] = SIGNAL_I.bus_status_seta;
            sel_oe[PIN_PA0] = 1'b1;
        end else if (ENABLE_I.bus_request_out_en) begin
            sel_out[PIN_PA0] = SIGNAL_I.bus_request_out;
            sel_oe[PIN_PA0] = 1'b1;
        end

        // PB3: chip selects; 3 wins if software sets both
        if (ENABLE_I.chip_select_three_en) begin
            sel_out[PIN_PB3] = SIGNAL_I.chip_select_three;
            sel_oe[PIN_PB3] = 1'b1;
        end else if (ENABLE_I.chip_select_seven_seta_en) begin
            sel_out[PIN_PB3] = SIGNAL_I.chip_select_seven_seta;
            sel_oe[PIN_PB3] = 1'b1;
        end

        // PB2: chip selects; 2 wins if software sets both
        if (ENABLE_I.chip_select_two_seta_en) begin
            sel_out[PIN_PB2] = SIGNAL_I.chip_select_two_seta;
            sel_oe[PIN_PB2] = 1'b1;
        end else if (ENABLE_I.chip_select_six_seta_en) begin
            sel_out[PIN_PB2] = SIGNAL_I.chip_select_six_seta;
            sel_oe[PIN_PB2] = 1'b1;
        end
    end

    // One registered output stage per pin
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pad
        pfs_pad_stage #(
            .INIT_OE(PAD_OE_RST[i]),
            .INIT_OUT(PAD_OUT_RST[i]),
            .BYPASS(PAD_BYPASS[i])
        ) u_pad (
            .clk(CLOCK_I),
            .arst_n(ARST_N_I),
            .sel_out(sel_out[i]),
            .sel_oe(sel_oe[i]),
            .pad_out(PIN_OUT_O[i]),
            .pad_oe(PIN_OE_O[i])
        );
    end

    // Input path: every pin level stays readable in any mode
    always_comb begin
        next_in = PIN_IN_I;
        // Bus request has priority over wait on the shared pin
        next_bus_req = ENABLE_I.bus_release_enable
            & PIN_IN_I[PIN_PA2];
        next_wait = ~ENABLE_I.bus_release_enable
            & ENABLE_I.wait_input_enable & PIN_IN_I[PIN_PA2];
    end

    // Input registers; data outputs come from flops
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            in_q <= '0;
            bus_req_q <= 1'b0;
            wait_q <= 1'b0;
        end else begin
            in_q <= next_in;
            bus_req_q <= next_bus_req;
            wait_q <= next_wait;
        end
    end

    assign PORT_IN_O = in_q;
    assign BUS_REQUEST_IN_O = bus_req_q;
    assign WAIT_IN_O = wait_q;

endmodule : pfs_pin_select

//--- tb/pfs_pin_select_props.sv
// Checker for the pin function selector
module pfs_pin_select_props
    import pfs_pkg::*;
(
    // Clock, reset and inputs
    input wire logic CLOCK_I,
    input wire logic ARST_N_I,
    input wire pfs_enable_s ENABLE_I,
    input wire pfs_signal_s SIGNAL_I,
    input wire logic [NUM_PINS-1:0] PIN_IN_I,
    input wire logic CLK_SRC_A_I,
    input wire logic CLK_SRC_B_I,
    input wire logic CLOCK_OUT_SELECT_BIT_I,
    // Outputs
    input wire logic [NUM_PINS-1:0] PIN_OUT_O,
    input wire logic [NUM_PINS-1:0] PIN_OE_O,
    input wire logic [NUM_PINS-1:0] PORT_IN_O,
    input wire logic BUS_REQUEST_IN_O
);
    // One clock; a reset abandons every check in flight
    default clocking @(posedge CLOCK_I);
    endclocking
    default disable iff (!ARST_N_I);

    chk_serial_tx: assert property (
        ENABLE_I.serial_ch4_tx_out_en |=> PIN_OE_O[PIN_P60] &&
        PIN_OUT_O[PIN_P60] == $past(SIGNAL_I.serial_ch4_transmit))
        else $error("serial tx pin wrong");
    chk_clock_kind: assert property (
        PIN_OUT_O[PIN_PA7] == (CLOCK_OUT_SELECT_BIT_I == CLK_SEL_SRC_B ?
        CLK_SRC_B_I : CLK_SRC_A_I)) else $error("clock kind wrong");
    chk_hold_first: assert property (
        ENABLE_I.addr_hold_out_en |=> PIN_OE_O[PIN_PA6] &&
        PIN_OUT_O[PIN_PA6] == $past(SIGNAL_I.addr_hold))
        else $error("pa6 select wrong");
    chk_read_strobe: assert property (
        ENABLE_I.external_expansion_enable |=> PIN_OE_O[PIN_PA5] &&
        PIN_OUT_O[PIN_PA5] == $past(SIGNAL_I.read_strobe))
        else $error("read strobe wrong");
    chk_upper_byte: assert property (
        (ENABLE_I.upper_byte_strobe_en || ENABLE_I.high_write_strobe_en) &&
        (ENABLE_I.byte_sram_access || ENABLE_I.high_write_strobe_out_en)
        |=> PIN_OE_O[PIN_PA4] &&
        PIN_OUT_O[PIN_PA4] == $past(SIGNAL_I.upper_byte_strobe))
        else $error("upper byte strobe wrong");
    chk_lower_byte: assert property (
        ENABLE_I.external_expansion_enable && ENABLE_I.byte_sram_access
        |=> PIN_OUT_O[PIN_PA3] == $past(SIGNAL_I.lower_byte_strobe))
        else $error("lower byte strobe wrong");
    chk_bus_request: assert property (
        ENABLE_I.bus_release_enable |=> !PIN_OE_O[PIN_PA2] &&
        BUS_REQUEST_IN_O == $past(PIN_IN_I[PIN_PA2]))
        else $error("bus request input wrong");
    chk_port_input: assert property (
        1'b1 |=> PORT_IN_O == $past(PIN_IN_I))
        else $error("port input path wrong");
endmodule : pfs_pin_select_props

bind pfs_pin_select pfs_pin_select_props pfs_pin_select_props_inst (.*);

//--- tb/pfs_pad_model.sv
// Pad wires: driven level, or the outside level when released
module pfs_pad_model
    import pfs_pkg::*;
(
    // Selector side
    input wire logic [NUM_PINS-1:0] pin_out_i,
    input wire logic [NUM_PINS-1:0] pin_oe_i,
    // Outside world
    input wire logic [NUM_PINS-1:0] ext_i,
    output logic [NUM_PINS-1:0] pin_o
);
    // Outside level changes freely so a stale drive cannot pass
    assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule : pfs_pad_model

//--- tb/pfs_pin_select_tb.sv
// Self-checking bench for the pin function selector
module pfs_pin_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pfs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pfs_enable_s en = 20'h0;
    pfs_signal_s sig = 17'h0;
    logic [10:0] dir = 11'h0, dat = 11'h0, ext = 11'h0;
    logic [10:0] pin, pout, poe, pin_rd, xoe, xo;
    logic ca = 1'b0, cb = 1'b0, csel = 1'b0, bus_req, wait_in;
    logic [31:0] lfsr = 32'h9f99a8d6;
    logic [21:0] expq[$];
    int errors = 0, n_checks = 0;

    always #5 clk = ~clk;

    pfs_pin_select pfs_pin_select_inst (.CLOCK_I(clk), .ARST_N_I(rst_n),
        .ENABLE_I(en), .SIGNAL_I(sig), .DIRECTION_I(dir), .PORT_DATA_I(dat),
        .CLK_SRC_A_I(ca), .CLK_SRC_B_I(cb), .CLOCK_OUT_SELECT_BIT_I(csel),
        .PIN_IN_I(pin), .PIN_OUT_O(pout), .PIN_OE_O(poe), .PORT_IN_O(pin_rd),
        .BUS_REQUEST_IN_O(bus_req), .WAIT_IN_O(wait_in));
    pfs_pad_model pfs_pad_model_inst (.pin_out_i(pout), .pin_oe_i(poe),
        .ext_i(ext), .pin_o(pin));

    // Shift register source of all random stimulus
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    // Marks pin k as driven by a module at level v
    function automatic void put(int k, logic v);
        xoe[k] = 1'b1;
        xo[k] = v;
    endfunction : put

    // Expected pin state: port default first, then the winning function per pin
    function automatic void expect_pins();
        xoe = dir;
        xo = dat;
        if (en.serial_ch4_tx_out_en) put(PIN_P60, sig.serial_ch4_transmit);
        if (en.addr_hold_out_en) put(PIN_PA6, sig.addr_hold);
        else if (en.bus_status_setb_out_en) put(PIN_PA6, sig.bus_status_setb);
        else if (en.addr_strobe_out_en) put(PIN_PA6, sig.addr_strobe);
        if (en.external_expansion_enable) put(PIN_PA5, sig.read_strobe);
        if (en.upper_byte_strobe_en | en.high_write_strobe_en)
            put(PIN_PA4, en.byte_sram_access | en.high_write_strobe_out_en ?
                sig.upper_byte_strobe : sig.high_write_strobe);
        if (en.external_expansion_enable)
            put(PIN_PA3, en.byte_sram_access ? sig.lower_byte_strobe :
                sig.low_write_strobe);
        if (en.bus_release_enable | en.wait_input_enable) xoe[PIN_PA2] = 1'b0;
        if (en.bus_ack_out_en) put(PIN_PA1, sig.bus_ack);
        else if (en.byte_sram_select | en.read_write_out_en)
            put(PIN_PA1, sig.read_write);
        if (en.bus_status_seta_out_en) put(PIN_PA0, sig.bus_status_seta);
        else if (en.bus_request_out_en) put(PIN_PA0, sig.bus_request_out);
        if (en.chip_select_three_en) put(PIN_PB3, sig.chip_select_three);
        else if (en.chip_select_seven_seta_en)
            put(PIN_PB3, sig.chip_select_seven_seta);
        if (en.chip_select_two_seta_en) put(PIN_PB2, sig.chip_select_two_seta);
        else if (en.chip_select_six_seta_en)
            put(PIN_PB2, sig.chip_select_six_seta);
    endfunction : expect_pins

    // One cycle of stimulus; the note is taken once inputs settle
    task automatic step(logic [19:0] e);
        logic [31:0] r, q;
        r = rnd();
        q = rnd();
        @(posedge clk);
        en <= e;
        sig <= r[16:0];
        {dir, dat} <= {r[31:17], q[6:0]};
        {ext, ca, cb, csel} <= q[20:7];
        @(negedge clk);
        expect_pins();
        expq.push_back({xoe, xo});
    endtask : step

    task automatic cmp(string nm, logic [10:0] e, logic [10:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    // Watcher: input path sampled at the edge, pins just after it
    always @(posedge clk) begin
        logic [21:0] x;
        logic [10:0] ps, m;
        logic br, wt;
        ps = pin;
        br = en.bus_release_enable;
        wt = en.wait_input_enable & ~br;
        #1;
        if (rst_n && expq.size() > 0) begin
            x = expq.pop_front();
            m = x[21:11] & ~PAD_BYPASS;
            cmp("driver enable", x[21:11], poe);
            cmp("pin level", x[10:0] & m, pout & m);
            cmp("clock out", {10'h0, csel ? cb : ca},
                {10'h0, pout[9]});
            cmp("port input", ps, pin_rd);
            cmp("bus inputs", {9'h0, br & ps[4], wt & ps[4]},
                {9'h0, bus_req, wait_in});
        end
    end

    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        cmp("reset enable", PAD_OE_RST, poe);
        cmp("reset level", PAD_OUT_RST, pout & ~PAD_BYPASS);
        rst_n <= 1'b1;
        $display("reset test done");
        for (int i = 0; i < 20; i++) step(20'h1 << i);
        step(20'hfffff);
        $display("single enable test done");
        repeat (600) step(20'(rnd() & rnd() & rnd()));
        $display("random mix test done");
        repeat (2) @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        cmp("mid reset enable", PAD_OE_RST, poe);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) step(20'(rnd() & rnd()));
        repeat (3) @(posedge clk);
        if (expq.size() > 0) errors++;
        $display("mid run reset test done");
        complete_run();
    end
endmodule : pfs_pin_select_tb
